// >>> pkg/smrpc_defs.vh
// Constants for the system management request packet codec
`ifndef SMRPC_DEFS_VH
`define SMRPC_DEFS_VH
// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define SMRPC_OFS_CTRL 4'h0
`define SMRPC_OFS_TXCODE 4'h1
`define SMRPC_OFS_TXADDR 4'h2
`define SMRPC_OFS_STATUS 4'h3
`define SMRPC_OFS_RXINFO 4'h4
`define SMRPC_OFS_DEVNUM 4'h5
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SMRPC_CTRL_SEND 0
`define SMRPC_CTRL_DOWN 1
`define SMRPC_CTRL_EXTEN 2
`define SMRPC_CTRL_HOST 3
`define SMRPC_CTRL_RXEN 4
// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SMRPC_ST_BUSY 0
`define SMRPC_ST_REFUSED 1
`define SMRPC_ST_RXSEEN 2
// ----------------------------------------------------------------
// Packet encodings
// ----------------------------------------------------------------
`define SMRPC_CMD_WRSIZED 6'h29
`define SMRPC_CMD_BCAST 6'h3A
`define SMRPC_TOP_SHUTDOWN 8'h04
`define SMRPC_TOP_HALT 8'h05
`define SMRPC_TOP_INTX 8'h0B
`define SMRPC_NIB_LINKMGT 4'h1
`define SMRPC_CTL_BYTES 3'h7
`define SMRPC_DATA_BYTES 2'h3
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SMRPC_RST_CTRL 5'h10
`define SMRPC_RST_CODE 12'h000
`define SMRPC_RST_DEVNUM 5'h00
`endif

// >>> hw/smrpc_codec.v
// System management request packet encoder and decoder with Avalon-MM registers
// Notes on behaviour
// - Upstream request is posted byte sized write
// - Upstream count zero, one mask doubleword follows
// - Mask doubleword all zero, ignored on receive
// - Chain and data error bits driven zero
// - Upstream command, code and address byte placement
// - Host broadcasts downstream, bit-times 2-3 reserved
// - Management packets recognised by address window
// - Same twelve-bit code for both directions
// - Code bits 11:4 are decoded, bits 3:1 for INTx only
// - Code 0000 0101 xxxx is HALT
// - Code 0000 0100 xxxx is SHUTDOWN
// - Code 0000 1011 xxxx is INTx message
// - Nonzero top nibble needs software enable
// - HALT and SHUTDOWN only sent by host
// - INTx wire select 00..11 is A..D
// - INTx sender puts own device number
`include "smrpc_defs.vh"

module smrpc_codec #(
    parameter [19:0] SM_WIN_BASE = 20'h00000, // Address bits 39:20 of window
    parameter [19:0] SM_WIN_MASK = 20'hFFFF0  // Bits compared against base
) (
    input wire ref_clk_i,            // Core clock
    input wire sys_rst_i,            // Synchronous reset, high
    input wire [3:0] avs_address_i,  // Word address
    input wire avs_read_i,           // Read request
    input wire avs_write_i,          // Write request
    input wire [31:0] avs_writedata_i, // Write data
    input wire [3:0] avs_byteenable_i, // Byte enables
    output reg [31:0] avs_readdata_o,  // Read data
    output reg avs_waitrequest_o,      // Stall
    output reg [7:0] tx_cad_o,         // Outgoing bit-time
    output reg tx_ctl_o,               // Outgoing bit-time is control
    output reg tx_valid_o,             // Outgoing bit-time valid
    input wire tx_ready_i,             // Link takes bit-time
    input wire [7:0] rx_cad_i,         // Incoming bit-time
    input wire rx_ctl_i,               // Incoming bit-time is control
    input wire rx_valid_i,             // Incoming bit-time valid
    output reg rx_halt_o,              // HALT received, pulse
    output reg rx_shutdown_o,          // SHUTDOWN received, pulse
    output reg rx_intx_o,              // INTx received, pulse
    output reg [1:0] rx_intx_wire_o,   // INTx wire, 0..3 = A..D
    output reg rx_intx_assert_o,       // INTx assert level
    output reg [4:0] rx_unit_o,        // Unit of received packet
    output reg rx_linkmgt_o            // Link-management code, pulse
);
    // ----------------------------------------------------------------
    // State encodings
    // ----------------------------------------------------------------
    localparam [1:0] TX_IDLE = 2'b00; // Nothing to send
    localparam [1:0] TX_CTL = 2'b01;  // Control bit-times
    localparam [1:0] TX_DAT = 2'b10;  // Mask doubleword
    localparam [1:0] RX_CTL = 2'b00;  // Gathering control bit-times
    localparam [1:0] RX_DAT = 2'b01;  // Skipping mask doubleword

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Packet byte for a given bit-time
    function [7:0] pkt_byte;
        input [2:0] idx;
        input down;
        input [11:0] code;
        input [4:0] unit;
        input [19:0] addr;
        begin
            case (idx)
                3'h0: pkt_byte = {2'b00, down ? `SMRPC_CMD_BCAST : `SMRPC_CMD_WRSIZED};
                3'h1: pkt_byte = {3'b000, unit};
                3'h2: pkt_byte = 8'h00;
                3'h3: pkt_byte = 8'h00;
                3'h4: pkt_byte = code[7:0];
                3'h5: pkt_byte = {addr[3:0], code[11:8]};
                3'h6: pkt_byte = addr[11:4];
                default: pkt_byte = addr[19:12];
            endcase
        end
    endfunction

    // Address lies in the management window
    function in_window;
        input [19:0] addr;
        begin
            in_window = ((addr ^ SM_WIN_BASE) & SM_WIN_MASK) == 20'h00000;
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [4:0] ctrl_reg;        // Direction, enables, role
    reg [11:0] code_reg;       // Code to send
    reg [4:0] unit_reg;        // Unit to send
    reg [19:0] addr_reg;       // Address bits 39:20 to send
    reg [4:0] devnum_reg;      // Own device number
    reg refused_reg;           // Sticky send refusal
    reg rxseen_reg;            // Sticky packet seen
    reg [11:0] rx_code_reg;    // Last accepted code
    reg rx_down_reg;           // Last was broadcast
    reg [1:0] tx_state_reg;    // Transmit state
    reg [2:0] tx_idx_reg;      // Transmit bit-time index
    reg [11:0] tx_code_reg;    // Latched code
    reg [4:0] tx_unit_reg;     // Latched unit
    reg [19:0] tx_addr_reg;    // Latched address
    reg tx_down_reg;           // Latched direction
    reg [1:0] rx_state_reg;    // Receive state
    reg [2:0] rx_idx_reg;      // Receive index
    reg [5:0] rx_cmd_reg;      // Received command
    reg [4:0] rx_unitc_reg;    // Received unit
    reg [7:0] rx_lo_reg;       // Received code low byte
    reg [11:0] rx_ahi_reg;     // Received code bits 11:8 and address bits 31:24

    // Bus access strobes, taken at the edge waitrequest is low
    wire wr_take = avs_write_i && !avs_waitrequest_o;
    wire send_req = wr_take && (avs_address_i == `SMRPC_OFS_CTRL)
        && avs_byteenable_i[0] && avs_writedata_i[`SMRPC_CTRL_SEND];
    wire busy = (tx_state_reg != TX_IDLE);
    wire [7:0] top8 = code_reg[11:4];
    wire is_hs = (top8 == `SMRPC_TOP_HALT) || (top8 == `SMRPC_TOP_SHUTDOWN);
    wire is_intx_tx = (top8 == `SMRPC_TOP_INTX);
    wire tx_hand = tx_valid_o && tx_ready_i;
    reg [3:0] rx_addr_lo; // Received address bits 23:20
    // Completed control part and its classification, declared early for the sticky bits
    wire rx_done = (rx_state_reg == RX_CTL) && rx_valid_i && rx_ctl_i
        && (rx_idx_reg == `SMRPC_CTL_BYTES);
    wire [19:0] rx_addr_full = {rx_cad_i, rx_ahi_reg[11:4], rx_addr_lo};
    wire [11:0] rx_code = {rx_ahi_reg[3:0], rx_lo_reg};
    wire rx_match = ((rx_cmd_reg == `SMRPC_CMD_WRSIZED) || (rx_cmd_reg == `SMRPC_CMD_BCAST))
        && in_window(rx_addr_full);

    // ----------------------------------------------------------------
    // Send admission
    // ----------------------------------------------------------------
    reg send_ok; // Request may be framed
    always @* begin
        send_ok = 1'b1;
        if ((code_reg[11:8] != 4'h0) && !ctrl_reg[`SMRPC_CTRL_EXTEN]) begin
            send_ok = 1'b0;
        end
        if (is_hs && !(ctrl_reg[`SMRPC_CTRL_HOST] && ctrl_reg[`SMRPC_CTRL_DOWN])) begin
            send_ok = 1'b0;
        end
        if (ctrl_reg[`SMRPC_CTRL_DOWN] && !ctrl_reg[`SMRPC_CTRL_HOST]) begin
            send_ok = 1'b0;
        end
        if (!in_window(addr_reg)) begin
            send_ok = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ----------------------------------------------------------------
    // Waitrequest drops for one cycle after a request is seen
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            case (avs_address_i)
                `SMRPC_OFS_CTRL: avs_readdata_o <= {27'h0, ctrl_reg[4:1], 1'b0};
                `SMRPC_OFS_TXCODE: avs_readdata_o <= {11'h0, unit_reg, 4'h0, code_reg};
                `SMRPC_OFS_TXADDR: avs_readdata_o <= {12'h000, addr_reg};
                `SMRPC_OFS_STATUS: avs_readdata_o <= {29'h0, rxseen_reg, refused_reg, busy};
                `SMRPC_OFS_RXINFO: avs_readdata_o <= {7'h0, rx_down_reg, 3'h0,
                    rx_unit_o, 4'h0, rx_code_reg};
                `SMRPC_OFS_DEVNUM: avs_readdata_o <= {27'h0, devnum_reg};
                // Unmapped reads as zero
                default: avs_readdata_o <= 32'h00000000;
            endcase
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Software writable registers; sticky bits set wins over clear
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= `SMRPC_RST_CTRL;
            code_reg <= `SMRPC_RST_CODE;
            unit_reg <= 5'h00;
            addr_reg <= SM_WIN_BASE;
            devnum_reg <= `SMRPC_RST_DEVNUM;
            refused_reg <= 1'b0;
            rxseen_reg <= 1'b0;
        end else begin
            if (wr_take) begin
                case (avs_address_i)
                    `SMRPC_OFS_CTRL: if (avs_byteenable_i[0]) begin
                        ctrl_reg <= {avs_writedata_i[4:1], 1'b0};
                    end
                    `SMRPC_OFS_TXCODE: begin
                        if (avs_byteenable_i[0]) code_reg[7:0] <= avs_writedata_i[7:0];
                        if (avs_byteenable_i[1]) code_reg[11:8] <= avs_writedata_i[11:8];
                        if (avs_byteenable_i[2]) unit_reg <= avs_writedata_i[20:16];
                    end
                    `SMRPC_OFS_TXADDR: begin
                        if (avs_byteenable_i[0]) addr_reg[7:0] <= avs_writedata_i[7:0];
                        if (avs_byteenable_i[1]) addr_reg[15:8] <= avs_writedata_i[15:8];
                        if (avs_byteenable_i[2]) addr_reg[19:16] <= avs_writedata_i[19:16];
                    end
                    `SMRPC_OFS_STATUS: if (avs_byteenable_i[0]) begin
                        if (avs_writedata_i[`SMRPC_ST_REFUSED]) refused_reg <= 1'b0;
                        if (avs_writedata_i[`SMRPC_ST_RXSEEN]) rxseen_reg <= 1'b0;
                    end
                    `SMRPC_OFS_DEVNUM: if (avs_byteenable_i[0]) begin
                        devnum_reg <= avs_writedata_i[4:0];
                    end
                    // Unmapped writes ignored
                    default: ;
                endcase
            end
            // Refusal when illegal or busy, wins over clear
            if (send_req && (!send_ok || busy)) refused_reg <= 1'b1;
            if (rx_done && rx_match && ctrl_reg[`SMRPC_CTRL_RXEN]) rxseen_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Transmit framer
    // ----------------------------------------------------------------
    // Latched copy lets software reprogram while a packet is in flight
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_state_reg <= TX_IDLE;
            tx_idx_reg <= 3'h0;
            tx_code_reg <= 12'h000;
            tx_unit_reg <= 5'h00;
            tx_addr_reg <= 20'h00000;
            tx_down_reg <= 1'b0;
            tx_cad_o <= 8'h00;
            tx_ctl_o <= 1'b0;
            tx_valid_o <= 1'b0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: if (send_req && send_ok) begin
                    tx_unit_reg <= is_intx_tx ? devnum_reg : unit_reg;
                    tx_code_reg <= code_reg;
                    tx_addr_reg <= addr_reg;
                    tx_down_reg <= ctrl_reg[`SMRPC_CTRL_DOWN];
                    tx_idx_reg <= 3'h0;
                    tx_cad_o <= pkt_byte(3'h0, ctrl_reg[`SMRPC_CTRL_DOWN], code_reg,
                        unit_reg, addr_reg);
                    tx_ctl_o <= 1'b1;
                    tx_valid_o <= 1'b1;
                    tx_state_reg <= TX_CTL;
                end
                TX_CTL: if (tx_hand) begin
                    if (tx_idx_reg != `SMRPC_CTL_BYTES) begin
                        tx_idx_reg <= tx_idx_reg + 3'h1;
                        tx_cad_o <= pkt_byte(tx_idx_reg + 3'h1, tx_down_reg, tx_code_reg,
                            tx_unit_reg, tx_addr_reg);
                    end else if (!tx_down_reg) begin
                        tx_idx_reg <= 3'h0;
                        tx_cad_o <= 8'h00;
                        tx_ctl_o <= 1'b0;
                        tx_state_reg <= TX_DAT;
                    end else begin
                        tx_valid_o <= 1'b0;
                        tx_ctl_o <= 1'b0;
                        tx_state_reg <= TX_IDLE;
                    end
                end
                TX_DAT: if (tx_hand) begin
                    if (tx_idx_reg[1:0] != `SMRPC_DATA_BYTES) begin
                        tx_idx_reg <= tx_idx_reg + 3'h1;
                    end else begin
                        tx_valid_o <= 1'b0;
                        tx_state_reg <= TX_IDLE;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Receive decoder
    // ----------------------------------------------------------------
    // Collect bit-times, then pulse the decoded event
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rx_state_reg <= RX_CTL;
            rx_idx_reg <= 3'h0;
            rx_cmd_reg <= 6'h00;
            rx_unitc_reg <= 5'h00;
            rx_lo_reg <= 8'h00;
            rx_ahi_reg <= 12'h000;
            rx_addr_lo <= 4'h0;
            rx_code_reg <= 12'h000;
            rx_down_reg <= 1'b0;
            rx_halt_o <= 1'b0;
            rx_shutdown_o <= 1'b0;
            rx_intx_o <= 1'b0;
            rx_intx_wire_o <= 2'b00;
            rx_intx_assert_o <= 1'b0;
            rx_unit_o <= 5'h00;
            rx_linkmgt_o <= 1'b0;
        end else begin
            rx_halt_o <= 1'b0;
            rx_shutdown_o <= 1'b0;
            rx_intx_o <= 1'b0;
            rx_linkmgt_o <= 1'b0;
            case (rx_state_reg)
                RX_CTL: if (rx_valid_i && rx_ctl_i) begin
                    rx_idx_reg <= rx_idx_reg + 3'h1;
                    case (rx_idx_reg)
                        3'h0: rx_cmd_reg <= rx_cad_i[5:0];
                        3'h1: rx_unitc_reg <= rx_cad_i[4:0];
                        3'h4: rx_lo_reg <= rx_cad_i;
                        3'h5: begin
                            rx_ahi_reg[3:0] <= rx_cad_i[3:0];
                            rx_addr_lo <= rx_cad_i[7:4];
                        end
                        3'h6: rx_ahi_reg[11:4] <= rx_cad_i;
                        default: ;
                    endcase
                    if (rx_done) begin
                        rx_idx_reg <= 3'h0;
                        // Skip mask doubleword of a sized write
                        if (rx_cmd_reg == `SMRPC_CMD_WRSIZED) rx_state_reg <= RX_DAT;
                        if (rx_match && ctrl_reg[`SMRPC_CTRL_RXEN]) begin
                            rx_code_reg <= rx_code;
                            rx_down_reg <= (rx_cmd_reg == `SMRPC_CMD_BCAST);
                            rx_unit_o <= rx_unitc_reg;
                            if (rx_code[11:8] == 4'h0) begin
                                if (rx_code[7:4] == 4'h5) rx_halt_o <= 1'b1;
                                if (rx_code[7:4] == 4'h4) rx_shutdown_o <= 1'b1;
                                if (rx_code[7:4] == 4'hB) begin
                                    rx_intx_o <= 1'b1;
                                    rx_intx_wire_o <= rx_code[3:2];
                                    rx_intx_assert_o <= rx_code[1];
                                end
                            end else if (rx_code[11:8] == `SMRPC_NIB_LINKMGT
                                && ctrl_reg[`SMRPC_CTRL_EXTEN]) begin
                                rx_linkmgt_o <= 1'b1;
                            end
                        end
                    end
                end
                RX_DAT: if (rx_valid_i && !rx_ctl_i) begin
                    rx_idx_reg <= rx_idx_reg + 3'h1;
                    if (rx_idx_reg[1:0] == `SMRPC_DATA_BYTES) begin
                        rx_idx_reg <= 3'h0;
                        rx_state_reg <= RX_CTL;
                    end
                end
                default: rx_state_reg <= RX_CTL;
            endcase
        end
    end
endmodule // smrpc_codec

// >>> dv/smrpc_link_peer.sv
// Link-side peer model: takes outgoing bit-times, sends management packets
module smrpc_link_peer (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Sync reset
    input wire logic [7:0] tx_cad_i, // Bit-time from block
    input wire logic tx_ctl_i, // Control flag from block
    input wire logic tx_valid_i, // Valid from block
    output logic tx_ready_o, // Take bit-time
    output logic [7:0] rx_cad_o = 8'h00, // Bit-time to block
    output logic rx_ctl_o = 1'b0, // Control flag to block
    output logic rx_valid_o = 1'b0 // Valid to block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cap [0:15]; // Captured {ctl, cad}
    int ncap = 0; // Capture count, cleared by bench
    logic [2:0] stl = 3'h0; // Stall phase
    // Stall two cycles in eight so held bytes get exercised
    assign tx_ready_o = (stl < 3'h6);
    always @(posedge clk_i) begin
        stl <= rst_i ? 3'h0 : stl + 3'h1;
        if (tx_valid_i && tx_ready_o && ncap < 16) begin
            cap[ncap] <= {tx_ctl_i, tx_cad_i};
            ncap <= ncap + 1;
        end
    end
    task send_pkt(input logic [5:0] cm, input logic [11:0] c, input logic [4:0] u,
                  input logic [19:0] a);
        logic [7:0] b [0:11];
        b = '{{2'b00, cm}, {3'h0, u}, 8'h00, 8'h00, c[7:0], {a[3:0], c[11:8]}, a[11:4],
              a[19:12], 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < (cm == 6'h29 ? 12 : 8); i++) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_ctl_o <= (i < 8);
            rx_cad_o <= b[i];
        end
        @(posedge clk_i);
        // Released lines show the inverse, never a stale copy
        rx_valid_o <= 1'b0;
        rx_ctl_o <= ~rx_ctl_o;
        rx_cad_o <= ~rx_cad_o;
    endtask
endmodule // smrpc_link_peer

// >>> dv/smrpc_assertions.sv
// Checker of bus answer, link framing and receive pulse timing
module smrpc_chk (
    input wire ref_clk_i, // Clock
    input wire sys_rst_i, // Reset
    input wire avs_read_i, // Read
    input wire avs_write_i, // Write
    input wire avs_waitrequest_o, // Stall
    input wire [7:0] tx_cad_o, // Tx byte
    input wire tx_ctl_o, // Tx control
    input wire tx_valid_o, // Tx valid
    input wire tx_ready_i, // Tx ready
    input wire rx_valid_i, // Rx valid
    input wire rx_ctl_i, // Rx control
    input wire rx_halt_o, // Halt pulse
    input wire rx_shutdown_o, // Shutdown pulse
    input wire rx_intx_o, // Intx pulse
    input wire rx_linkmgt_o // Link pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
    sequence s_ans; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
    property p_bus; s_req |=> s_ans; endproperty
    a_bus: assert property (p_bus) else $error("bus answer late or long");
    property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_ctl_o, tx_cad_o});
    endproperty
    a_hold: assert property (p_hold) else $error("tx byte moved while stalled");
    property p_head; $rose(tx_valid_o) |-> tx_ctl_o && (tx_cad_o == 8'h29 || tx_cad_o == 8'h3A);
    endproperty
    a_head: assert property (p_head) else $error("bad command byte");
    property p_unit; $rose(tx_valid_o) ##0 tx_ready_i |=> tx_ctl_o && tx_cad_o[7:5] == 3'h0;
    endproperty
    a_unit: assert property (p_unit) else $error("bad unit byte");
    property p_mask; tx_valid_o && !tx_ctl_o |-> tx_cad_o == 8'h00; endproperty
    a_mask: assert property (p_mask) else $error("mask byte not zero");
    property p_pls; rx_halt_o |=> !rx_halt_o; endproperty
    a_pls: assert property (p_pls) else $error("halt pulse too long");
    property p_one; $onehot0({rx_halt_o, rx_shutdown_o, rx_intx_o, rx_linkmgt_o}); endproperty
    a_one: assert property (p_one) else $error("two request kinds at once");
    property p_cause; (rx_halt_o || rx_shutdown_o || rx_intx_o || rx_linkmgt_o)
        |-> $past(rx_valid_i && rx_ctl_i); endproperty
    a_cause: assert property (p_cause) else $error("pulse without packet");
endmodule // smrpc_chk
bind smrpc_codec smrpc_chk u_chk (.ref_clk_i, .sys_rst_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .tx_cad_o, .tx_ctl_o, .tx_valid_o, .tx_ready_i, .rx_valid_i,
    .rx_ctl_i, .rx_halt_o, .rx_shutdown_o, .rx_intx_o, .rx_linkmgt_o);

// >>> dv/tb.sv
// Self-checking bench for the management request codec
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdat;
    logic avs_waitrequest_o, tx_ctl_o, tx_valid_o, tx_ready_i, rx_ctl_i, rx_valid_i;
    logic [7:0] tx_cad_o, rx_cad_i;
    logic rx_halt_o, rx_shutdown_o, rx_intx_o, rx_intx_assert_o, rx_linkmgt_o;
    logic [1:0] rx_intx_wire_o;
    logic [4:0] rx_unit_o;
    logic [3:0] seen; // Pulses seen {halt, shut, intx, link}
    logic [11:0] c;
    integer seed = 32'h1639;
    int n_errors = 0, num_checks = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    smrpc_codec uut (.ref_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .tx_cad_o,
        .tx_ctl_o, .tx_valid_o, .tx_ready_i, .rx_cad_i, .rx_ctl_i, .rx_valid_i, .rx_halt_o,
        .rx_shutdown_o, .rx_intx_o, .rx_intx_wire_o, .rx_intx_assert_o, .rx_unit_o,
        .rx_linkmgt_o);
    smrpc_link_peer peer (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .tx_cad_i(tx_cad_o),
        .tx_ctl_i(tx_ctl_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
        .rx_cad_o(rx_cad_i), .rx_ctl_o(rx_ctl_i), .rx_valid_o(rx_valid_i));
    // Gather receive pulses between packets
    always @(posedge ref_clk_i)
        seen <= seen | {rx_halt_o, rx_shutdown_o, rx_intx_o, rx_linkmgt_o};
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // One bus access, held until waitrequest is seen low
    task acc(input logic r, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_read_i <= r;
        avs_write_i <= !r;
        avs_writedata_i <= d;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20) chk(32'h1, 32'h0);
        rdat = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // Expected {ctl, cad} of outgoing bit-time i
    function automatic [8:0] eb(int i, logic dn, logic [11:0] k, logic [4:0] u);
        case (i)
            0: eb = {3'b100, dn ? `SMRPC_CMD_BCAST : `SMRPC_CMD_WRSIZED};
            1: eb = {4'h8, u};
            4: eb = {1'b1, k[7:0]};
            5: eb = {5'h10, k[11:8]};
            default: eb = {i < 8, 8'h00};
        endcase
    endfunction
    task txc(input logic [4:0] cfg, input logic [11:0] k, input logic ok);
        int n, j;
        logic [4:0] u;
        u = 5'($random(seed));
        acc(0, 4'h1, {11'h0, u, 4'h0, k});
        acc(0, 4'h0, {27'h0, cfg});
        peer.ncap = 0;
        acc(0, 4'h0, {27'h0, cfg | 5'h01});
        n = ok ? (cfg[1] ? 8 : 12) : 0;
        j = 0;
        while ((tx_valid_o !== 1'b0 || j < 3) && j < 200) begin @(negedge ref_clk_i); j++; end
        chk(peer.ncap, n);
        for (j = 0; j < n; j++) chk(peer.cap[j], eb(j, cfg[1], k, k[11:4] == 8'h0B ? 5'h13 : u));
        acc(1, 4'h3, 0);
        chk(rdat[1], !ok);
        acc(0, 4'h3, 32'h6);
        $display("tx case %0h done", k);
    endtask
    task rxc(input logic [5:0] cm, input logic [11:0] k, input logic [19:0] a, input logic [3:0] e);
        @(negedge ref_clk_i);
        seen = 4'h0;
        peer.send_pkt(cm, k, 5'h0B, a);
        repeat (4) @(posedge ref_clk_i);
        chk(seen, e);
        if (e[1]) chk({rx_intx_wire_o, rx_intx_assert_o, rx_unit_o}, {k[3:1], 5'h0B});
        $display("rx case %0h done", k);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            acc(1, i == 6 ? 4'hA : 4'(i), 0);
            chk(rdat, i == 0 ? 32'h10 : 32'h0);
        end
        acc(0, 4'hA, $random(seed));
        acc(1, 4'hA, 0);
        chk(rdat, 0);
        acc(0, 4'h5, 32'h13);
        txc(5'h10, {8'h0B, 4'($random(seed)) & 4'hE}, 1);
        txc(5'h1A, 12'h053, 1);
        txc(5'h1A, 12'h041, 1);
        txc(5'h10, 12'h050, 0);
        txc(5'h18, 12'h040, 0);
        txc(5'h12, 12'h0B0, 0);
        txc(5'h10, 12'h123, 0);
        txc(5'h14, 12'h123, 1);
        repeat (6) begin
            c = {4'h0, 8'($random(seed))};
            txc(5'h10, c, c[7:4] != 4'h4 && c[7:4] != 4'h5);
        end
        rxc(6'h3A, 12'h051, 20'h0, 4'h8);
        rxc(6'h3A, 12'h04F, 20'h0, 4'h4);
        for (int w = 0; w < 4; w++) rxc(6'h29, {8'h0B, 2'(w), w[0], 1'b0}, 20'h0, 4'h2);
        rxc(6'h3A, 12'h0E5, 20'h0, 4'h0);
        rxc(6'h3A, 12'h205, 20'h0, 4'h0);
        rxc(6'h3A, 12'h051, 20'h00100, 4'h0);
        rxc(6'h29, 12'h151, 20'h0, 4'h0);
        acc(0, 4'h0, 32'h14);
        rxc(6'h29, 12'h151, 20'h0, 4'h1);
        acc(0, 4'h0, 32'h0);
        rxc(6'h3A, 12'h051, 20'h0, 4'h0);
        complete_run;
    end
endmodule // tb
